// ### core/cmp_consts.svh
// Constants for the execution mode and privilege control block
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CMP_AW 8
`define CMP_OFS_STATUS 8'h00
`define CMP_OFS_PEND 8'h04
`define CMP_OFS_CAUSE 8'h08
`define CMP_OFS_RSRDBG 8'h0c

`define CMP_SR_RST 32'h0040_0000
`define CMP_LOW_MASK 32'h0000_ffff
`define CMP_HIGH_MASK 32'hffff_0000
`define CMP_FLAG_LSB 0
`define CMP_FLAG_W 5
`define CMP_MASK_LSB 17
`define CMP_MASK_W 4
`define CMP_MODE_LSB 22
`define CMP_MODE_W 3
`define CMP_DBG_BIT 27

`define CMP_NMODES 8
`define CMP_PEND_IRQ_LSB 2
`define CMP_PEND_EXC 6
`define CMP_PEND_NMI 7

`define CMP_IDX_W 7
`define CMP_SR_APP_IDX 7'h42
`define CMP_CAUSE_VIOL 0
`define CMP_CAUSE_OP_LSB 4
`define CMP_OP_W 3

`define CMP_HTRANS_NONSEQ 2'b10
`define CMP_HSIZE_WORD 3'h2
`define CMP_HRESP_OKAY 1'b0

`endif

// ### core/cmp_pkg.sv
// Types for the execution mode and privilege control block
`include "cmp_consts.svh"
package cmp_pkg;
	typedef enum logic [2:0] {
		MD_APP = 3'h0,
		MD_SUP = 3'h1,
		MD_INT0 = 3'h2,
		MD_INT1 = 3'h3,
		MD_INT2 = 3'h4,
		MD_INT3 = 3'h5,
		MD_EXC = 3'h6,
		MD_NMI = 3'h7
	} cmp_mode_t;
	typedef enum logic [2:0] {
		OP_MEM = 3'h0,
		OP_PRIV = 3'h1,
		OP_SRRD = 3'h2,
		OP_SRWR = 3'h3,
		OP_MEMPROT = 3'h4,
		OP_SRMEM = 3'h5,
		OP_DRET = 3'h6
	} cmp_op_t;
	typedef enum logic [1:0] {
		RS_RUN = 2'b01,
		RS_DBG = 2'b10
	} cmp_run_t;
	typedef struct packed {logic valid; cmp_op_t op; logic [`CMP_IDX_W-1:0] srIdx;} cmp_chk_req_t;
	typedef struct packed {logic grant; logic deny;} cmp_chk_rsp_t;
	typedef struct packed {logic nmi; logic exc; logic [`CMP_MASK_W-1:0] irq;} cmp_req_t;
	typedef struct packed {logic upd; logic [`CMP_FLAG_W-1:0] val;} cmp_flag_t;
	typedef struct packed {logic taken; cmp_mode_t newMode; cmp_mode_t oldMode;} cmp_evt_t;
	typedef struct packed {
		cmp_run_t run;
		logic [31:0] sw;
		logic [31:0] rsrDbg;
		logic excPend;
		logic viol;
		cmp_op_t cause;
		logic wrPend;
		logic [`CMP_AW-1:0] wrAddr;
		logic [31:0] hrdata;
		cmp_chk_rsp_t rsp;
		cmp_evt_t evt;
	} cmp_state_t;
endpackage : cmp_pkg

// ### core/cmp_prio_arb.sv
// Picks the highest pending mode and decides preemption
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_prio_arb (
	input wire logic [`CMP_NMODES-1:0] pend,
	input cmp_pkg::cmp_mode_t cur,
	output logic preempt,
	output cmp_pkg::cmp_mode_t top
);
	logic hit;

	// Mode code equals priority, so the highest set bit wins
	always_comb begin
		hit = 1'b0;
		top = cmp_pkg::MD_APP;
		for (int i = 0; i < `CMP_NMODES; i++) begin
			if (pend[i]) begin
				hit = 1'b1;
				top = cmp_pkg::cmp_mode_t'(3'(i));
			end
		end
		preempt = hit && (top > cur);
	end
endmodule : cmp_prio_arb

// ### core/cmp_mode_ctrl.sv
// Execution mode, privilege and debug state control with an AHB-Lite register port
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_mode_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input cmp_pkg::cmp_req_t intReq,
	input cmp_pkg::cmp_flag_t flagIn,
	input wire logic dbgEnter,
	input cmp_pkg::cmp_chk_req_t chkReq,
	output cmp_pkg::cmp_chk_rsp_t chkRsp,
	output cmp_pkg::cmp_evt_t modeEvt,
	output logic [31:0] statusWord,
	output cmp_pkg::cmp_mode_t curMode,
	output logic privileged,
	output logic debugState
);

	localparam cmp_pkg::cmp_state_t ST_RST = '{
		run: cmp_pkg::RS_RUN,
		sw: `CMP_SR_RST,
		rsrDbg: 32'h0000_0000,
		excPend: 1'b0,
		viol: 1'b0,
		cause: cmp_pkg::OP_MEM,
		wrPend: 1'b0,
		wrAddr: 8'h00,
		hrdata: 32'h0000_0000,
		rsp: 2'b00,
		evt: 7'h00
	};

	cmp_pkg::cmp_state_t stQ;
	cmp_pkg::cmp_state_t stD;

	logic inDebug;
	logic isSys;
	logic [`CMP_NMODES-1:0] pendVec;
	logic preempt;
	cmp_pkg::cmp_mode_t topMode;
	cmp_pkg::cmp_mode_t modeNow;
	logic addrPhase;
	logic chkDenied;
	logic dretNow;

	// System mode, or any mode while in debug state
	function automatic logic hasPriv(
		input cmp_pkg::cmp_mode_t mode,
		input logic dbg
	);
		hasPriv = dbg || (mode != cmp_pkg::MD_APP);
	endfunction : hasPriv

	// Decides whether a core access must be refused
	function automatic logic denyAccess(
		input cmp_pkg::cmp_op_t op,
		input logic [`CMP_IDX_W-1:0] idx,
		input logic priv
	);
		denyAccess = 1'b0;
		unique case (op)
			cmp_pkg::OP_MEM: begin
				denyAccess = 1'b0;
			end
			cmp_pkg::OP_SRMEM: begin
				denyAccess = 1'b1;
			end
			cmp_pkg::OP_PRIV,
			cmp_pkg::OP_DRET: begin
				denyAccess = !priv;
			end
			cmp_pkg::OP_SRRD,
			cmp_pkg::OP_SRWR: begin
				denyAccess = !priv && (idx != `CMP_SR_APP_IDX);
			end
			cmp_pkg::OP_MEMPROT: begin
				denyAccess = !priv;
			end
			default: begin
				denyAccess = 1'b1;
			end
		endcase
	endfunction : denyAccess

	// Register read view
	function automatic logic [31:0] regRead(
		input logic [`CMP_AW-1:0] addr,
		input cmp_pkg::cmp_state_t s,
		input logic [`CMP_NMODES-1:0] pend
	);
		regRead = 32'h0000_0000;
		case (addr)
			`CMP_OFS_STATUS: begin
				regRead = s.sw;
			end
			`CMP_OFS_PEND: begin
				regRead[`CMP_NMODES-1:0] = pend;
			end
			`CMP_OFS_CAUSE: begin
				regRead[`CMP_CAUSE_VIOL] = s.viol;
				regRead[`CMP_CAUSE_OP_LSB +: `CMP_OP_W] = s.cause;
			end
			`CMP_OFS_RSRDBG: begin
				regRead = s.rsrDbg;
			end
			default: begin
				regRead = 32'h0000_0000;
			end
		endcase
	endfunction : regRead

	assign inDebug = (stQ.run == cmp_pkg::RS_DBG);
	assign modeNow = cmp_pkg::cmp_mode_t'(stQ.sw[`CMP_MODE_LSB +: `CMP_MODE_W]);
	assign isSys = hasPriv(modeNow, inDebug);

	// Requests per mode; masked interrupt levels drop out
	always_comb begin
		pendVec = '0;
		pendVec[`CMP_PEND_NMI] = intReq.nmi;
		pendVec[`CMP_PEND_EXC] = intReq.exc || stQ.excPend;
		pendVec[`CMP_PEND_IRQ_LSB +: `CMP_MASK_W] =
			intReq.irq & ~stQ.sw[`CMP_MASK_LSB +: `CMP_MASK_W];
	end

	cmp_prio_arb u_arb (
		.pend(pendVec),
		.cur(modeNow),
		.preempt(preempt),
		.top(topMode)
	);

	assign addrPhase = hsel && hready && (htrans == `CMP_HTRANS_NONSEQ) &&
		(hsize == `CMP_HSIZE_WORD);
	assign chkDenied = chkReq.valid && denyAccess(chkReq.op, chkReq.srIdx, isSys);
	assign dretNow = chkReq.valid && !chkDenied && inDebug &&
		(chkReq.op == cmp_pkg::OP_DRET);

	always_comb begin
		stD = stQ;
		stD.rsp = '0;
		stD.evt = '0;

		// Data phase of a write taken in the previous cycle
		if (stQ.wrPend) begin
			case (stQ.wrAddr)
				`CMP_OFS_STATUS: begin
					if (isSys) begin
						// Software mode change and mask edits
						stD.sw = hwdata;
					end else begin
						// Upper half stays untouched in application mode
						stD.sw = (stQ.sw & `CMP_HIGH_MASK) |
							(hwdata & `CMP_LOW_MASK);
					end
					// Debug flag follows the state machine only
					stD.sw[`CMP_DBG_BIT] = stQ.sw[`CMP_DBG_BIT];
				end
				`CMP_OFS_CAUSE: begin
					if (hwdata[`CMP_CAUSE_VIOL]) begin
						stD.viol = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Condition flags from the execution stage
		if (flagIn.upd) begin
			stD.sw[`CMP_FLAG_LSB +: `CMP_FLAG_W] = flagIn.val;
		end

		// Accept an interrupt or exception of higher priority
		if (preempt && !dretNow) begin
			stD.evt.taken = 1'b1;
			stD.evt.oldMode = modeNow;
			stD.evt.newMode = topMode;
			stD.sw[`CMP_MODE_LSB +: `CMP_MODE_W] = topMode;
			if (topMode == cmp_pkg::MD_EXC) begin
				stD.excPend = 1'b0;
			end
		end

		// Core access check, answered one cycle later
		if (chkReq.valid) begin
			stD.rsp.grant = !chkDenied;
			stD.rsp.deny = chkDenied;
			if (chkDenied) begin
				// Set after any clear, so a new violation is kept
				stD.viol = 1'b1;
				stD.excPend = 1'b1;
				stD.cause = chkReq.op;
			end
		end

		// Leave debug state and restore the saved upper half
		if (dretNow) begin
			stD.run = cmp_pkg::RS_RUN;
			stD.sw = (stD.sw & `CMP_LOW_MASK) | (stQ.rsrDbg & `CMP_HIGH_MASK);
			stD.sw[`CMP_DBG_BIT] = 1'b0;
		end

		// Enter debug state with every interrupt level masked
		if (dbgEnter && !inDebug) begin
			stD.rsrDbg = stD.sw;
			stD.run = cmp_pkg::RS_DBG;
			stD.sw[`CMP_DBG_BIT] = 1'b1;
			stD.sw[`CMP_MASK_LSB +: `CMP_MASK_W] = '1;
		end

		// Address phase; writes land next cycle
		stD.wrPend = addrPhase && hwrite;
		stD.wrAddr = haddr[`CMP_AW-1:0];
		if (addrPhase && !hwrite) begin
			// Read the next state so a write just before is seen
			stD.hrdata = regRead(haddr[`CMP_AW-1:0], stD, pendVec);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stQ <= ST_RST;
		end else begin
			stQ <= stD;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = `CMP_HRESP_OKAY;
	assign hrdata = stQ.hrdata;
	assign chkRsp = stQ.rsp;
	assign modeEvt = stQ.evt;
	assign statusWord = stQ.sw;
	assign curMode = modeNow;
	assign privileged = isSys;
	assign debugState = inDebug;

endmodule : cmp_mode_ctrl

// ### bench/cmp_mode_sva.sv
// Concurrent checks on the mode control block ports
`timescale 1ns/1ps
module cmp_mode_sva (
	input wire logic clk,
	input wire logic rst,
	input cmp_pkg::cmp_req_t intReq,
	input cmp_pkg::cmp_chk_req_t chkReq,
	input cmp_pkg::cmp_chk_rsp_t chkRsp,
	input cmp_pkg::cmp_evt_t modeEvt,
	input wire logic [31:0] statusWord,
	input cmp_pkg::cmp_mode_t curMode,
	input wire logic privileged,
	input wire logic debugState
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_super: assert property (
		$past(rst) |-> curMode == cmp_pkg::MD_SUP && !debugState) else $error("bad reset mode");
	a_check_once: assert property (
		chkReq.valid |=> chkRsp.grant != chkRsp.deny) else $error("check answer");
	a_app_refuse: assert property (
		chkReq.valid && !privileged && chkReq.op inside {cmp_pkg::OP_PRIV, cmp_pkg::OP_MEMPROT,
		cmp_pkg::OP_DRET} |=> chkRsp.deny) else $error("app not refused");
	a_sysreg_path: assert property (
		chkReq.valid && chkReq.op == cmp_pkg::OP_SRMEM |=> chkRsp.deny) else $error("sysreg via mem");
	a_system_grant: assert property (
		chkReq.valid && privileged && chkReq.op != cmp_pkg::OP_SRMEM |=> chkRsp.grant)
		else $error("system mode refused");
	a_preempt_up: assert property (
		modeEvt.taken |-> modeEvt.newMode > modeEvt.oldMode && curMode == modeEvt.newMode)
		else $error("bad preemption");
	a_deny_exc: assert property (
		chkRsp.deny && curMode < cmp_pkg::MD_EXC && !intReq.nmi |=> curMode == cmp_pkg::MD_EXC)
		else $error("no exception mode");
	a_debug_mask: assert property (
		$rose(debugState) |-> statusWord[20:17] == 4'hf && statusWord[27]) else $error("masks");
	a_priv_level: assert property (
		privileged == (curMode != cmp_pkg::MD_APP || debugState)) else $error("privilege level");
endmodule : cmp_mode_sva

// ### bench/cmp_irq_src.sv
// Interrupt sources that hold a level until its mode is taken
`timescale 1ns/1ps
module cmp_irq_src (
	input wire logic clk,
	input wire logic rst,
	input cmp_pkg::cmp_req_t raise,
	input cmp_pkg::cmp_evt_t evt,
	output cmp_pkg::cmp_req_t req
);
	logic [5:0] n;
	always @(posedge clk) begin
		n = req | raise;
		if (evt.taken && evt.newMode >= cmp_pkg::MD_INT0) n[evt.newMode - 3'h2] = 1'b0;
		req <= rst ? '0 : n;
	end
endmodule : cmp_irq_src

// ### bench/cmp_mode_ctrl_test.sv
// Self-checking bench for the mode and privilege control block
`timescale 1ns/1ps
module cmp_mode_ctrl_test;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, dbgEnter = 0, e;
	logic hreadyout, hresp, privileged, debugState;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, statusWord, r, f;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic [2:0] o, lastOp = 3'h0;
	logic vio = 1'b0;
	cmp_pkg::cmp_req_t intReq, raise = '0;
	cmp_pkg::cmp_flag_t flagIn = '0;
	cmp_pkg::cmp_chk_req_t chkReq = '0;
	cmp_pkg::cmp_chk_rsp_t chkRsp, k;
	cmp_pkg::cmp_evt_t modeEvt;
	cmp_pkg::cmp_mode_t curMode;
	int fail_count = 0, compares = 0;
	always #20 clk = ~clk;
	cmp_mode_ctrl cmp_mode_ctrl_inst (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .intReq, .flagIn, .dbgEnter, .chkReq,
		.chkRsp, .modeEvt, .statusWord, .curMode, .privileged, .debugState);
	cmp_irq_src cmp_irq_src_inst (.clk, .rst, .raise, .evt(modeEvt), .req(intReq));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic chk(input cmp_pkg::cmp_op_t op, input logic [6:0] idx);
		@(posedge clk);
		chkReq <= '{1'b1, op, idx};
		@(posedge clk);
		chkReq.valid <= 1'b0;
		@(posedge clk);
		k = chkRsp;
	endtask : chk
	task automatic fire(input logic [5:0] v, input cmp_pkg::cmp_mode_t m);
		@(posedge clk);
		raise <= v;
		@(posedge clk);
		raise <= '0;
		repeat (3) @(posedge clk);
		cmp(curMode, m);
	endtask : fire
	// App mode is refused all but plain memory and the one open system register
	function automatic logic deny_exp(input logic [2:0] op, input logic [6:0] idx);
		return op == 3'h5 || op != 3'h0 && !(op inside {3'h2, 3'h3} && idx == 7'h42);
	endfunction : deny_exp
	task automatic final_report;
		if (fail_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		final_report;
	end
	initial begin
		void'($urandom(32'hda66));
		f = $urandom & 32'hff;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 8'h00, 32'h0);
		cmp(r, 32'h0040_0000);
		bus(1'b0, 8'h10, 32'h0);
		cmp(r, 32'h0);
		cmp({hreadyout, hresp}, 2'b10);
		flagIn <= '{1'b1, ~f[4:0]};
		@(posedge clk);
		flagIn.upd <= 1'b0;
		@(posedge clk);
		cmp(statusWord[4:0], {~f[4:0]});
		for (int i = 0; i < 8; i++) begin
			o = 3'(i + 7);
			bus(1'b1, 8'h00, f);
			bus(1'b1, 8'h00, 32'h0040_0000 | f ^ 32'h1f);
			bus(1'b0, 8'h00, 32'h0);
			cmp(r, f ^ 32'h1f);
			chk(cmp_pkg::cmp_op_t'(o == 3'h7 ? 3'h2 : o), o == 3'h7 ? 7'h42 : 7'($urandom));
			e = deny_exp(o == 3'h7 ? 3'h2 : o, chkReq.srIdx);
			// Cause keeps the last refused op; the violation bit is sticky
			if (e) begin
				lastOp = (o == 3'h7) ? 3'h2 : o;
				vio = 1'b1;
			end
			cmp({k.grant, k.deny}, {~e, e});
			repeat (2) @(posedge clk);
			cmp({privileged, curMode, statusWord[7:0]}, {e, e ? 3'h6 : 3'h0, f[7:0] ^ 8'h1f});
			bus(1'b0, 8'h08, 32'h0);
			cmp({r[6:4], r[0]}, {lastOp, vio});
		end
		bus(1'b1, 8'h08, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		cmp({r[6:4], r[0]}, {lastOp, 1'b0});
		bus(1'b1, 8'h00, 32'h0040_0000 | f);
		fire(6'h02, cmp_pkg::MD_INT1);
		fire(6'h01, cmp_pkg::MD_INT1);
		bus(1'b0, 8'h04, 32'h0);
		cmp(r, 32'h4);
		fire(6'h20, cmp_pkg::MD_NMI);
		bus(1'b1, 8'h00, 32'h0040_0000 | f);
		fire(6'h00, cmp_pkg::MD_INT0);
		bus(1'b1, 8'h00, 32'h0040_0000 | f);
		@(posedge clk);
		dbgEnter <= 1'b1;
		@(posedge clk);
		dbgEnter <= 1'b0;
		@(posedge clk);
		cmp({debugState, statusWord[20:17]}, 32'h1f);
		bus(1'b0, 8'h0c, 32'h0);
		cmp(r, 32'h0040_0000 | f);
		bus(1'b1, 8'h00, 32'h005a_0000 | f);
		bus(1'b0, 8'h00, 32'h0);
		cmp(r, 32'h085a_0000 | f);
		fire(6'h04, cmp_pkg::MD_SUP);
		bus(1'b0, 8'h04, 32'h0);
		cmp(r, 32'h0);
		fire(6'h02, cmp_pkg::MD_INT1);
		chk(cmp_pkg::OP_DRET, 7'h0);
		cmp(k.grant, 1'b1);
		cmp({debugState, statusWord[20:17]}, 32'h0);
		fire(6'h00, cmp_pkg::MD_INT2);
		// Reset in mid-run must bring back supervisor mode
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cmp({debugState, curMode, statusWord}, {1'b0, 3'h1, 32'h0040_0000});
		final_report;
	end
endmodule : cmp_mode_ctrl_test
bind cmp_mode_ctrl cmp_mode_sva cmp_mode_sva_inst (.clk, .rst, .intReq, .chkReq, .chkRsp,
	.modeEvt, .statusWord, .curMode, .privileged, .debugState);
